// ==== logic/uhr_holding_regs.sv ====
// Purpose: Holding registers, divisor low byte and interrupt-enable register
// Assumes: sys_rst is power-on reset; soft_rst is any other reset; the
//          oscillator gate sits outside and the wake detector keeps mclk
// Notes:   Contract
`timescale 1ns/10ps
`default_nettype none
module uhr_holding_regs #(
    parameter int DEPTH = uhr_pkg::FIFO_DEPTH
) (
    // Clock and resets
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       soft_rst,
    // Register access from the serial slave front end
    input  wire logic [3:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_wr_refused,
    // Settings held by other register banks
    input  wire logic [7:0] line_control,
    input  wire logic [7:0] enhanced_function,
    input  wire logic       fifo_mode,
    input  wire logic [1:0] tx_trig_sel,
    // Serial engine side
    input  wire logic       rx_push,
    input  wire logic [7:0] rx_byte,
    input  wire logic       tx_pop,
    output logic      [7:0] tx_byte,
    input  wire logic       int_pending,
    // Pins, asynchronous
    input  wire logic       rx_pin,
    input  wire logic [3:0] modem_pins,
    // Status and enables
    output logic            rx_full,
    output logic            rx_empty,
    output logic            tx_full,
    output logic            tx_empty,
    output logic      [7:0] baud_divisor_low,
    output logic      [7:0] interrupt_enable,
    output logic            ie_cts_dsr,
    output logic            ie_rts_dtr,
    output logic            ie_swflow,
    output logic            ie_modem,
    output logic            ie_line,
    output logic            ie_rxrdy,
    output logic            tx_ready_irq,
    output logic            sleep_en,
    output logic            osc_stop
);
    localparam int AW = $clog2(DEPTH);
    // Receive line idles high, so the synchroniser starts there and no false wake follows reset
    localparam logic [1:0] RX_SYNC_IDLE = 2'h3;

    // ==========================================================
    // Elaboration check
    if (DEPTH != (1 << AW) || DEPTH <= uhr_pkg::TXTRIG_3) begin : g_bad_depth
        $error("DEPTH must be a power of two above the top trigger level");
    end
    if (uhr_pkg::TXTRIG_0 >= uhr_pkg::TXTRIG_1 || uhr_pkg::TXTRIG_1 >= uhr_pkg::TXTRIG_2
        || uhr_pkg::TXTRIG_2 >= uhr_pkg::TXTRIG_3) begin : g_bad_trig
        $error("Transmit trigger levels must rise with the select code");
    end

    // ==========================================================
    // State
    typedef struct packed {
        // FIFO storage and pointers
        logic [DEPTH-1:0][7:0] rx_mem;
        logic [DEPTH-1:0][7:0] tx_mem;
        logic [AW:0]           rx_wp;
        logic [AW:0]           rx_rp;
        logic [AW:0]           tx_wp;
        logic [AW:0]           tx_rp;
        // Register bus answer
        logic [7:0]            rdata;
        logic                  refused;
        // Programmed registers
        logic [7:0]            divlo;
        logic [7:0]            ie;
        // Sleep and pin synchronisers
        uhr_pkg::uhr_sleep_t   slp;
        logic [1:0]            rx_sync;
        logic [3:0]            mdm_s1;
        logic [3:0]            mdm_s2;
        logic [3:0]            mdm_s3;
    } uhr_state_t;

    uhr_state_t st_ff;
    uhr_state_t nxt_st;

    // ==========================================================
    // Functions
    // Read answer for one strobe; write-only and unmapped offsets answer zero
    function automatic logic [7:0] read_value(
        input logic       pick_rx,
        input logic       pick_ie,
        input logic [7:0] rx_head,
        input logic [7:0] ie_val
    );
        if (pick_rx) begin
            read_value = rx_head;
        end else if (pick_ie) begin
            read_value = ie_val;
        end else begin
            read_value = uhr_pkg::RDATA_RST;
        end
    endfunction

    // Wraps correctly because the pointers carry one extra bit
    function automatic logic [AW:0] fill_level(input logic [AW:0] wp, input logic [AW:0] rp);
        fill_level = wp - rp;
    endfunction

    // Extra pointer bit tells full from empty when the low bits meet
    function automatic logic fifo_is_full(input logic [AW:0] wp, input logic [AW:0] rp);
        fifo_is_full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    endfunction

    // Trigger levels are counted in free spaces
    function automatic logic [AW:0] trig_spaces(input logic [1:0] sel);
        case (sel)
            2'h0:    trig_spaces = (AW+1)'(uhr_pkg::TXTRIG_0);
            2'h1:    trig_spaces = (AW+1)'(uhr_pkg::TXTRIG_1);
            2'h2:    trig_spaces = (AW+1)'(uhr_pkg::TXTRIG_2);
            default: trig_spaces = (AW+1)'(uhr_pkg::TXTRIG_3);
        endcase
    endfunction

    // ==========================================================
    // Decode
    logic       bank_hi;
    logic       dl_bank;
    logic       enh_on;
    logic       hold_sel;
    logic       ie_sel;
    logic       dl_sel;
    logic       rx_rd;
    logic       tx_wr;
    logic       tx_take;
    logic       rx_take;
    logic       rx_drop;
    logic       tx_drop;
    logic       mdm_chg;
    logic       tx_room;
    logic       rx_low;
    logic       slp_ok;
    logic       wake_req;
    logic [AW:0] tx_free;

    always_comb begin
        // Bank and register select
        bank_hi  = line_control[uhr_pkg::LC_BANK_BIT];
        dl_bank  = bank_hi && (line_control != uhr_pkg::LC_ENH_KEY);
        enh_on   = enhanced_function[uhr_pkg::EF_ENH_BIT];
        hold_sel = !bank_hi && (reg_addr == uhr_pkg::OFS_HOLD);
        ie_sel   = !bank_hi && (reg_addr == uhr_pkg::OFS_IE);
        dl_sel   = dl_bank && (reg_addr == uhr_pkg::OFS_HOLD);

        // FIFO flags from the pointer pairs
        rx_full  = fifo_is_full(st_ff.rx_wp, st_ff.rx_rp);
        rx_empty = (st_ff.rx_wp == st_ff.rx_rp);
        tx_full  = fifo_is_full(st_ff.tx_wp, st_ff.tx_rp);
        tx_empty = (st_ff.tx_wp == st_ff.tx_rp);

        // Strobes and their effect on the FIFOs
        rx_rd    = reg_rd && hold_sel;
        tx_wr    = reg_wr && hold_sel;
        rx_take  = rx_rd && !rx_empty;
        tx_take  = tx_wr && !tx_full;
        tx_drop  = tx_wr && tx_full;
        // Engine pops the head; a pop on an empty FIFO is ignored
        rx_drop  = tx_pop && !tx_empty;

        // Transmit room against the selected trigger level
        tx_free  = (AW+1)'(DEPTH) - fill_level(st_ff.tx_wp, st_ff.tx_rp);
        // In FIFO mode, free spaces strictly above the selected level raise the request; otherwise an empty FIFO does
        tx_room  = fifo_mode ? (tx_free > trig_spaces(tx_trig_sel)) : tx_empty;

        // Only the two settled stages are compared; the first stage stays private
        mdm_chg  = (st_ff.mdm_s2 != st_ff.mdm_s3);
        // A receive pulse shorter than a clock may be missed by the synchroniser
        rx_low   = !st_ff.rx_sync[1];
        // Sleep entry needs every idle condition in the same cycle
        slp_ok   = sleep_en
                   && !int_pending
                   && !mdm_chg
                   && !rx_low
                   && rx_empty
                   && tx_empty
                   && !tx_take;
        // Dropping the enable also wakes, so the clock never stays stopped without leave
        wake_req = mdm_chg
                   || rx_low
                   || tx_take
                   || !sleep_en;
    end

    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.refused = 1'b0;
        // Pin synchronisers
        nxt_st.rx_sync = {st_ff.rx_sync[0], rx_pin};
        nxt_st.mdm_s1  = modem_pins;
        nxt_st.mdm_s2  = st_ff.mdm_s1;
        nxt_st.mdm_s3  = st_ff.mdm_s2;

        // Receive FIFO: push from the engine, overrun bytes are dropped
        if (rx_push && !rx_full) begin
            nxt_st.rx_mem[st_ff.rx_wp[AW-1:0]] = rx_byte;
            nxt_st.rx_wp = st_ff.rx_wp + 1'b1;
        end
        // Empty read returns whatever the slot holds; host must discard it
        if (reg_rd) begin
            nxt_st.rdata = read_value(rx_rd, ie_sel, st_ff.rx_mem[st_ff.rx_rp[AW-1:0]], st_ff.ie);
        end
        // Pop only when something is there, so an empty read leaves the pointers alone
        if (rx_take) begin
            nxt_st.rx_rp = st_ff.rx_rp + 1'b1;
        end

        // Transmit FIFO
        if (tx_take) begin
            nxt_st.tx_mem[st_ff.tx_wp[AW-1:0]] = reg_wdata;
            nxt_st.tx_wp = st_ff.tx_wp + 1'b1;
        end
        nxt_st.refused = tx_drop;
        if (rx_drop) begin
            nxt_st.tx_rp = st_ff.tx_rp + 1'b1;
        end

        // Divisor low byte and interrupt enable
        if (reg_wr && dl_sel) begin
            nxt_st.divlo = reg_wdata;
        end
        if (reg_wr && ie_sel) begin
            // Upper nibble is locked unless the enhanced bit is set
            nxt_st.ie[3:0] = reg_wdata[3:0];
            if (enh_on) begin
                nxt_st.ie[7:4] = reg_wdata[7:4];
            end
        end

        // Sleep control
        case (st_ff.slp)
            uhr_pkg::SLP_AWAKE: begin
                if (slp_ok) begin
                    nxt_st.slp = uhr_pkg::SLP_ASLEEP;
                end
            end
            uhr_pkg::SLP_ASLEEP: begin
                if (wake_req) begin
                    nxt_st.slp = uhr_pkg::SLP_AWAKE;
                end
            end
            default: begin
                nxt_st.slp = uhr_pkg::SLP_AWAKE;
            end
        endcase

        // Any reset other than power-on keeps the divisor low byte
        if (soft_rst) begin
            nxt_st.rx_wp   = '0;
            nxt_st.rx_rp   = '0;
            nxt_st.tx_wp   = '0;
            nxt_st.tx_rp   = '0;
            nxt_st.rdata   = uhr_pkg::RDATA_RST;
            nxt_st.refused = 1'b0;
            nxt_st.ie      = uhr_pkg::IE_RST;
            nxt_st.slp     = uhr_pkg::SLP_AWAKE;
            nxt_st.divlo   = st_ff.divlo;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge mclk) begin
        // Power-on reset; the divisor only returns to its default here
        if (sys_rst) begin
            st_ff         <= '0;
            st_ff.rdata   <= uhr_pkg::RHOLD_RST;
            st_ff.divlo   <= uhr_pkg::DIVLO_RST;
            st_ff.ie      <= uhr_pkg::IE_RST;
            st_ff.slp     <= uhr_pkg::SLP_AWAKE;
            st_ff.rx_sync <= RX_SYNC_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        // Register contents
        reg_rdata        = st_ff.rdata;
        reg_wr_refused   = st_ff.refused;
        tx_byte          = st_ff.tx_mem[st_ff.tx_rp[AW-1:0]];
        baud_divisor_low = st_ff.divlo;
        interrupt_enable = st_ff.ie;

        // Enable bits as separate lines; sleep enable gated by the enhanced bit, transmit ready by room
        ie_cts_dsr       = st_ff.ie[uhr_pkg::IE_CTS_DSR];
        ie_rts_dtr       = st_ff.ie[uhr_pkg::IE_RTS_DTR];
        ie_swflow        = st_ff.ie[uhr_pkg::IE_SWFLOW];
        ie_modem         = st_ff.ie[uhr_pkg::IE_MODEM];
        ie_line          = st_ff.ie[uhr_pkg::IE_LINE];
        ie_rxrdy         = st_ff.ie[uhr_pkg::IE_RXRDY];
        sleep_en         = st_ff.ie[uhr_pkg::IE_SLEEP] && enh_on;
        tx_ready_irq     = st_ff.ie[uhr_pkg::IE_TXRDY] && tx_room;

        // Power control
        osc_stop         = (st_ff.slp == uhr_pkg::SLP_ASLEEP);
    end
endmodule // uhr_holding_regs
`default_nettype wire

// ==== logic/uhr_pkg.sv ====
// Purpose: Shared constants and types for the holding and interrupt-enable bank
// Assumes: Registers are reached by a 4-bit internal register address
// Notes:   Used by uhr_holding_regs
`default_nettype none
package uhr_pkg;
    // ==========================================================
    // Register offsets and bank selection
    localparam logic [3:0] OFS_HOLD      = 4'h0;
    localparam logic [3:0] OFS_IE        = 4'h1;
    localparam int         LC_BANK_BIT   = 7;
    localparam logic [7:0] LC_ENH_KEY    = 8'hBF;
    localparam int         EF_ENH_BIT    = 4;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RHOLD_RST     = 8'h00;
    localparam logic [7:0] DIVLO_RST     = 8'h01;
    localparam logic [7:0] IE_RST        = 8'h00;
    localparam logic [7:0] RDATA_RST     = 8'h00;
    // ==========================================================
    // Interrupt-enable fields
    localparam int         IE_CTS_DSR    = 7;
    localparam int         IE_RTS_DTR    = 6;
    localparam int         IE_SWFLOW     = 5;
    localparam int         IE_SLEEP      = 4;
    localparam int         IE_MODEM      = 3;
    localparam int         IE_LINE       = 2;
    localparam int         IE_TXRDY      = 1;
    localparam int         IE_RXRDY      = 0;
    localparam logic [7:0] IE_ENH_MASK   = 8'hF0;
    // ==========================================================
    // FIFO depth and transmit trigger levels in free spaces
    localparam int         FIFO_DEPTH    = 64;
    localparam int         TXTRIG_0      = 8;
    localparam int         TXTRIG_1      = 16;
    localparam int         TXTRIG_2      = 32;
    localparam int         TXTRIG_3      = 56;
    // ==========================================================
    // Sleep state, one-hot
    typedef enum logic [1:0] {
        SLP_AWAKE  = 2'h1,
        SLP_ASLEEP = 2'h2
    } uhr_sleep_t;
endpackage
`default_nettype wire

// ==== verif/uhr_chk.sv ====
// Purpose: Port-level assertions for the holding and interrupt-enable bank
// Assumes: sys_rst and soft_rst are synchronous and active high
// Notes:   Bound to every instance of uhr_holding_regs
`timescale 1ns/10ps
`default_nettype none
module uhr_chk (
    // Clock, resets and register access
    input wire logic       mclk, sys_rst, soft_rst, reg_wr, rx_push, tx_pop, fifo_mode, int_pending,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata, line_control, enhanced_function, baud_divisor_low, interrupt_enable,
    // Status and enables
    input wire logic       reg_rd, reg_wr_refused, rx_full, rx_empty, tx_full, tx_empty, tx_ready_irq,
    input wire logic       ie_cts_dsr, ie_rts_dtr, ie_swflow, ie_modem, ie_line, ie_rxrdy, sleep_en, osc_stop
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic hold0;
    assign hold0 = reg_addr == 4'h0 && !line_control[7] && !soft_rst;
    // ==========================================================
    // Holding registers and divisor low byte
    property p_rx_pop; reg_rd && hold0 && !rx_empty && !rx_push |=> !rx_full; endproperty
    a_rx_pop: assert property (p_rx_pop) else $error("read left receive full");
    property p_tx_push; reg_wr && hold0 && !tx_full && !tx_pop |=> !tx_empty; endproperty
    a_tx_push: assert property (p_tx_push) else $error("write not queued");
    property p_tx_drop; reg_wr && hold0 && tx_full && !tx_pop |=> reg_wr_refused && tx_full; endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("full write not refused");
    property p_div_wr; reg_wr && reg_addr == 4'h0 && line_control[7] && line_control != 8'hBF && !soft_rst
        |=> baud_divisor_low == $past(reg_wdata); endproperty
    a_div_wr: assert property (p_div_wr) else $error("divisor write lost");
    property p_div_key; reg_wr && line_control == 8'hBF |=> $stable(baud_divisor_low); endproperty
    a_div_key: assert property (p_div_key) else $error("divisor written under key");
    property p_div_keep; soft_rst |=> $stable(baud_divisor_low); endproperty
    a_div_keep: assert property (p_div_keep) else $error("divisor cleared by soft reset");
    // ==========================================================
    // Interrupt enable and sleep
    property p_ie_lock; reg_wr && reg_addr == 4'h1 && !line_control[7] && !soft_rst && !enhanced_function[4]
        |=> $stable(interrupt_enable[7:4]) && interrupt_enable[3:0] == $past(reg_wdata[3:0]); endproperty
    a_ie_lock: assert property (p_ie_lock) else $error("enable write wrong");
    property p_ie_bits; {ie_cts_dsr, ie_rts_dtr, ie_swflow, ie_modem, ie_line, ie_rxrdy}
        == {interrupt_enable[7:5], interrupt_enable[3:2], interrupt_enable[0]}; endproperty
    a_ie_bits: assert property (p_ie_bits) else $error("enable outputs wrong");
    property p_sleep_en; sleep_en == (interrupt_enable[4] && enhanced_function[4]); endproperty
    a_sleep_en: assert property (p_sleep_en) else $error("sleep enable wrong");
    property p_sleep_in; $rose(osc_stop) |-> $past(sleep_en && tx_empty && rx_empty && !int_pending); endproperty
    a_sleep_in: assert property (p_sleep_in) else $error("slept while busy");
    property p_wake; osc_stop && reg_wr && hold0 && !tx_full |=> !osc_stop; endproperty
    a_wake: assert property (p_wake) else $error("no wake on load");
    property p_txrdy; !fifo_mode |-> tx_ready_irq == (interrupt_enable[1] && tx_empty); endproperty
    a_txrdy: assert property (p_txrdy) else $error("transmit ready wrong");
    c_sleep: cover property ($rose(osc_stop));
    c_drop: cover property (reg_wr_refused);
    c_keep: cover property (soft_rst && baud_divisor_low != 8'h01);
endmodule // uhr_chk
bind uhr_holding_regs uhr_chk i_chk (.*);
`default_nettype wire

// ==== verif/uhr_host.sv ====
// Purpose: Host model issuing register strobes to the bank
// Assumes: One access in flight, a quiet cycle between accesses
// Notes:   Idle address and data are scrambled so stale values never help
`timescale 1ns/10ps
`default_nettype none
module uhr_host (
    input  wire logic       mclk,
    output logic      [3:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge mclk);
        #2;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        @(posedge mclk);
        #2;
    endtask
endmodule // uhr_host
`default_nettype wire

// ==== verif/tb_uart_holding_irq_enable_regs.sv ====
// Purpose: Self-checking bench for the holding and interrupt-enable bank
// Assumes: Inputs change 2 ns after the rising edge
// Notes:   Read answers are queued when issued, checked when they appear
`timescale 1ns/10ps
`default_nettype none
module tb_uart_holding_irq_enable_regs;
    logic       mclk, sys_rst, soft_rst, reg_wr, reg_rd, reg_wr_refused, fifo_mode, rx_push, tx_pop, rd_d;
    logic       int_pending, rx_pin, rx_full, rx_empty, tx_full, tx_empty, tx_ready_irq, sleep_en, osc_stop;
    logic       ie_cts_dsr, ie_rts_dtr, ie_swflow, ie_modem, ie_line, ie_rxrdy;
    logic [1:0] tx_trig_sel;
    logic [3:0] reg_addr, modem_pins;
    logic [7:0] reg_wdata, reg_rdata, line_control, enhanced_function, rx_byte, tx_byte;
    logic [7:0] baud_divisor_low, interrupt_enable, v, t [64];
    logic [8:0] e, exp_q [$];
    int         num_errors = 0, checks = 0, refusals = 0, lv [4] = '{8, 16, 32, 56};
    uhr_holding_regs i_dut (.*);
    uhr_host i_host (.*);
    // ==========================================================
    // Clock, watchdog, monitor and tasks
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        #100000;
        num_errors++;
        results();
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task results;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // Bit 8 of a note marks an answer the host must discard
    task rd(input logic [3:0] a, input logic [8:0] x);
        exp_q.push_back(x);
        i_host.acc(a, 1'b0, 8'h00);
    endtask
    always @(posedge mclk) begin
        rd_d <= reg_rd;
        if (reg_wr_refused === 1'b1) refusals++;
        if (rd_d === 1'b1) begin
            e = exp_q.pop_front();
            if (e[8] === 1'b0) chk(reg_rdata, e[7:0]);
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        {sys_rst, rx_pin} = 2'b11;
        {soft_rst, fifo_mode, rx_push, tx_pop, int_pending, tx_trig_sel, modem_pins} = 11'h000;
        {line_control, enhanced_function, rx_byte} = 24'h000000;
        void'($urandom(85));
        tick(3);
        sys_rst = 1'b0;
        chk(baud_divisor_low, 8'h01);
        chk({4'h0, rx_empty, tx_empty, rx_full, tx_full}, 8'h0C);
        rd(4'h1, 9'h000);
        for (int i = 0; i < 3; i++) begin
            t[i] = 8'($urandom);
            rx_byte = t[i];
            rx_push = 1'b1;
            tick(1);
        end
        rx_push = 1'b0;
        for (int i = 0; i < 3; i++) rd(4'h0, {1'b0, t[i]});
        chk(8'(rx_empty), 8'h01);
        rd(4'h0, 9'h100);
        line_control = 8'h80;
        v = 8'($urandom);
        i_host.acc(4'h0, 1'b1, v);
        chk(baud_divisor_low, v);
        rd(4'h0, 9'h000);
        line_control = 8'hBF;
        i_host.acc(4'h0, 1'b1, ~v);
        line_control = 8'h00;
        soft_rst = 1'b1;
        tick(1);
        soft_rst = 1'b0;
        chk(baud_divisor_low, v);
        i_host.acc(4'h1, 1'b1, 8'hFF);
        rd(4'h1, 9'h00F);
        enhanced_function = 8'h10;
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'h5A : 8'hA5;
            i_host.acc(4'h1, 1'b1, v);
            rd(4'h1, {1'b0, v});
            chk({ie_cts_dsr, ie_rts_dtr, ie_swflow, sleep_en, ie_modem, ie_line, 1'b0, ie_rxrdy}, v & 8'hFD);
        end
        tick(4);
        chk(8'(osc_stop), 8'h01);
        rx_pin = 1'b0;
        tick(5);
        chk(8'(osc_stop), 8'h00);
        {int_pending, rx_pin} = 2'b11;
        tick(5);
        chk(8'(osc_stop), 8'h00);
        int_pending = 1'b0;
        tick(5);
        chk(8'(osc_stop), 8'h01);
        modem_pins = 4'($urandom) | 4'h1;
        tick(3);
        chk(8'(osc_stop), 8'h00);
        tick(1);
        chk(8'(osc_stop), 8'h01);
        fifo_mode = 1'b1;
        for (int i = 0; i < 64; i++) begin
            t[i] = 8'($urandom);
            i_host.acc(4'h0, 1'b1, t[i]);
        end
        chk({6'h00, osc_stop, tx_full}, 8'h01);
        i_host.acc(4'h0, 1'b1, ~t[0]);
        chk(8'(refusals), 8'h01);
        for (int i = 0; i < 64; i++) begin
            tx_trig_sel = 2'($urandom);
            tx_pop = 1'b1;
            #1;
            chk(tx_byte, t[i]);
            chk(8'(tx_ready_irq), 8'(i > lv[tx_trig_sel]));
            @(posedge mclk);
            #2;
        end
        {tx_pop, fifo_mode} = 2'b00;
        tick(1);
        chk({6'h00, tx_empty, tx_ready_irq}, 8'h03);
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        chk(baud_divisor_low, 8'h01);
        rd(4'h1, 9'h000);
        tick(3);
        results();
    end
endmodule // tb_uart_holding_irq_enable_regs
`default_nettype wire
